// ---- inc/cpo_map.svh ----
`ifndef CPO_MAP_SVH
`define CPO_MAP_SVH
// register byte addresses (word aligned)
`define CPO_CTRL_ADDR 8'h00
`define CPO_LOW_ADDR 8'h04
`define CPO_HIGH_ADDR 8'h08
`define CPO_PULSES_ADDR 8'h0C
`define CPO_DIV_ADDR 8'h10
`define CPO_SFILT_ADDR 8'h14
`define CPO_GFILT_ADDR 8'h18
`define CPO_STATUS_ADDR 8'h1C
// control field positions
`define CPO_CTRL_START_BIT 0
`define CPO_CTRL_MODE_LSB 1
`define CPO_CTRL_MODE_MSB 2
`define CPO_CTRL_SRC_LSB 3
`define CPO_CTRL_SRC_MSB 4
`define CPO_CTRL_INV_BIT 5
`define CPO_CTRL_GATE_EN_BIT 6
`define CPO_CTRL_GATE_POL_BIT 7
// reset values
`define CPO_CTRL_RST 32'h0000_0000
`define CPO_SFILT_RST 32'h0000_0000
`define CPO_GFILT_RST 32'h0000_0000
`define CPO_LOW_RST 32'h0000_0001
`define CPO_HIGH_RST 32'h0000_0001
`define CPO_PULSES_RST 32'h0000_0001
`define CPO_DIV_RST 32'h0000_0001
// filter widths count in milliseconds of the system clock
`define CPO_MS_NS 1000000
`define CPO_CLK_NS 40
`define CPO_CYC_PER_MS (`CPO_MS_NS / `CPO_CLK_NS)
// documented internal timebase rate
`define CPO_INT_TB_HZ 66000000
`endif

// ---- inc/cpo_pkg.sv ----
package cpo_pkg;
  // generation mode
  typedef enum logic [1:0] {
    CPO_MODE_SINGLE = 2'h0,
    CPO_MODE_NPULSE = 2'h1,
    CPO_MODE_CONT = 2'h2
  } cpo_mode_e;
  // sequencer state, gray along idle->low->high->done
  typedef enum logic [1:0] {
    CPO_ST_IDLE = 2'h0,
    CPO_ST_LOW = 2'h1,
    CPO_ST_HIGH = 2'h3,
    CPO_ST_DONE = 2'h2
  } cpo_state_e;
  typedef logic [31:0] cpo_word_t;
endpackage

// ---- rtl/cpo_counter_output.sv ----
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cpo_map.svh"
// How it works
// - mode field picks single pulse, n pulses or endless train.
// - low and high durations count whole ticks of the chosen timebase.
// - source select field picks which clock input is the timebase.
// - output stays low for exactly low_tick_count ticks each period.
// - output stays high for exactly high_tick_count ticks each period.
// - filtered gate on lets generation run, gate off freezes the counter.
// - invert bit flips the source before ticks are taken from it.
// - source edges are divided by the programmed divider to make ticks.
// - n-pulse mode emits exactly pulse_total_setting pulses.
// - source pulses shorter than the programmed milliseconds are ignored.
// - gate pulses shorter than the programmed milliseconds are ignored.
module cpo_counter_output #(
  parameter int SRC_COUNT = 4,
  parameter int CYC_PER_MS = `CPO_CYC_PER_MS
) (
  // system
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output cpo_pkg::cpo_word_t avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic [SRC_COUNT-1:0] src_in,
  input wire logic gate_in,
  output logic pulse_out
);
  import cpo_pkg::*;

  // select width; a single source still needs one select bit
  localparam int SW = (SRC_COUNT > 1) ? $clog2(SRC_COUNT) : 1;

  // settings as software left them
  cpo_word_t ctrl_reg, low_reg, high_reg, pulses_reg, div_reg, sfilt_reg, gfilt_reg;
  // bus answer pending
  logic ack_reg;
  logic start_pulse;
  logic src_filt_reg, gate_filt_reg, src_prev_reg;
  cpo_word_t div_cnt_reg, tick_cnt_reg, pulse_cnt_reg;
  cpo_state_e state_reg;
  logic [31:0] sflt_cnt_reg, gflt_cnt_reg, sflt_ms_reg, gflt_ms_reg;

  // merge byte lanes into a register word
  function automatic cpo_word_t merge(input cpo_word_t old, input cpo_word_t wd,
                                      input logic [3:0] be);
    cpo_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // a zero setting behaves as one so a period is never empty
  function automatic cpo_word_t at_least_one(input cpo_word_t v);
    return (v == 32'h0000_0000) ? 32'h0000_0001 : v;
  endfunction

  // an access is answered on the edge after it is seen, so each takes two edges;
  // the trade is one wait state for a registered, glitch-free waitrequest
  wire rd_hit = avs_read && !ack_reg;
  // writes land at the answering edge, where the master sees waitrequest low
  wire wr_hit = avs_write && ack_reg;

  // one wait cycle per access; answer on the second edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
    end
  end

  // a write to one register address at the answering edge
  function automatic logic wr_at(input logic [7:0] a);
    return wr_hit && (avs_address == a);
  endfunction

  // start is a self-clearing pulse; it is never stored in the control word
  assign start_pulse = wr_at(`CPO_CTRL_ADDR) && avs_byteenable[0]
                       && avs_writedata[`CPO_CTRL_START_BIT];

  // control word; the start bit is masked so it always reads back as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CPO_CTRL_RST;
    end else if (wr_at(`CPO_CTRL_ADDR)) begin
      ctrl_reg <= merge(ctrl_reg, avs_writedata, avs_byteenable) & 32'h0000_00FE;
    end
  end

  // low phase length in ticks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_reg <= `CPO_LOW_RST;
    end else if (wr_at(`CPO_LOW_ADDR)) begin
      low_reg <= merge(low_reg, avs_writedata, avs_byteenable);
    end
  end

  // high phase length in ticks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_reg <= `CPO_HIGH_RST;
    end else if (wr_at(`CPO_HIGH_ADDR)) begin
      high_reg <= merge(high_reg, avs_writedata, avs_byteenable);
    end
  end

  // pulse total for the n-pulse mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulses_reg <= `CPO_PULSES_RST;
    end else if (wr_at(`CPO_PULSES_ADDR)) begin
      pulses_reg <= merge(pulses_reg, avs_writedata, avs_byteenable);
    end
  end

  // timebase divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= `CPO_DIV_RST;
    end else if (wr_at(`CPO_DIV_ADDR)) begin
      div_reg <= merge(div_reg, avs_writedata, avs_byteenable);
    end
  end

  // source filter width in ms
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfilt_reg <= `CPO_SFILT_RST;
    end else if (wr_at(`CPO_SFILT_ADDR)) begin
      sfilt_reg <= merge(sfilt_reg, avs_writedata, avs_byteenable);
    end
  end

  // gate filter width in ms
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gfilt_reg <= `CPO_GFILT_RST;
    end else if (wr_at(`CPO_GFILT_ADDR)) begin
      gfilt_reg <= merge(gfilt_reg, avs_writedata, avs_byteenable);
    end
  end

  // read mux; unmapped addresses read zero
  // status exposes the sequencer state so software can poll for done
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      unique case (avs_address)
        `CPO_CTRL_ADDR: avs_readdata <= ctrl_reg;
        `CPO_LOW_ADDR: avs_readdata <= low_reg;
        `CPO_HIGH_ADDR: avs_readdata <= high_reg;
        `CPO_PULSES_ADDR: avs_readdata <= pulses_reg;
        `CPO_DIV_ADDR: avs_readdata <= div_reg;
        `CPO_SFILT_ADDR: avs_readdata <= sfilt_reg;
        `CPO_GFILT_ADDR: avs_readdata <= gfilt_reg;
        `CPO_STATUS_ADDR: avs_readdata <= {28'h0000000, gate_filt_reg, pulse_out,
                                           state_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // raw source: selected and optionally inverted
  wire [SW-1:0] src_sel = ctrl_reg[`CPO_CTRL_SRC_MSB:`CPO_CTRL_SRC_LSB];
  wire src_raw = src_in[src_sel] ^ ctrl_reg[`CPO_CTRL_INV_BIT];

  // glitch filter: input must hold a new level for width ms before it is taken.
  // a ms prescaler per filter keeps the width counter small-step and exact.
  // limitation: width resolution is one ms; a zero width passes the pin straight.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_filt_reg <= 1'b0;
      sflt_cnt_reg <= 32'h0000_0000;
      sflt_ms_reg <= 32'h0000_0000;
    end else if (src_raw == src_filt_reg || sfilt_reg == 32'h0000_0000) begin
      src_filt_reg <= src_raw;
      sflt_cnt_reg <= 32'h0000_0000;
      sflt_ms_reg <= 32'h0000_0000;
    end else if (sflt_cnt_reg == 32'(CYC_PER_MS - 1)) begin
      sflt_cnt_reg <= 32'h0000_0000;
      sflt_ms_reg <= sflt_ms_reg + 32'h0000_0001;
      if (sflt_ms_reg + 32'h0000_0001 >= sfilt_reg) begin
        src_filt_reg <= src_raw;
      end
    end else begin
      sflt_cnt_reg <= sflt_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_filt_reg <= 1'b0;
      gflt_cnt_reg <= 32'h0000_0000;
      gflt_ms_reg <= 32'h0000_0000;
    end else if (gate_in == gate_filt_reg || gfilt_reg == 32'h0000_0000) begin
      gate_filt_reg <= gate_in;
      gflt_cnt_reg <= 32'h0000_0000;
      gflt_ms_reg <= 32'h0000_0000;
    end else if (gflt_cnt_reg == 32'(CYC_PER_MS - 1)) begin
      gflt_cnt_reg <= 32'h0000_0000;
      gflt_ms_reg <= gflt_ms_reg + 32'h0000_0001;
      if (gflt_ms_reg + 32'h0000_0001 >= gfilt_reg) begin
        gate_filt_reg <= gate_in;
      end
    end else begin
      gflt_cnt_reg <= gflt_cnt_reg + 32'h0000_0001;
    end
  end

  // gate on when disabled, else filtered gate at chosen polarity
  // gate off holds the output level: a high phase simply stretches
  wire gate_on = !ctrl_reg[`CPO_CTRL_GATE_EN_BIT] ||
                 (gate_filt_reg ^ ctrl_reg[`CPO_CTRL_GATE_POL_BIT]);

  // rising edge of the filtered source
  // the detector resets to the filter's reset level, so no false edge after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_filt_reg;
    end
  end

  wire src_edge = src_filt_reg && !src_prev_reg;

  // divider: one tick every div_reg source edges; gate off freezes it
  // a divider change applies at once to the running count; a start clears the count
  wire tick = src_edge && gate_on && (div_cnt_reg >= at_least_one(div_reg) - 32'h0000_0001);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 32'h0000_0000;
    end else if (start_pulse) begin
      div_cnt_reg <= 32'h0000_0000;
    end else if (src_edge && gate_on) begin
      div_cnt_reg <= tick ? 32'h0000_0000 : div_cnt_reg + 32'h0000_0001;
    end
  end

  // pulse sequencer: low phase then high phase, counted in ticks.
  // the end tests are shared by the state and counter processes so
  // a phase length and its state change can never disagree.
  function automatic logic phase_over(input cpo_word_t cnt, input cpo_word_t len);
    return (cnt + 32'h0000_0001) >= at_least_one(len);
  endfunction

  cpo_mode_e mode_sel;
  assign mode_sel = cpo_mode_e'(ctrl_reg[`CPO_CTRL_MODE_MSB:`CPO_CTRL_MODE_LSB]);

  wire low_over = (state_reg == CPO_ST_LOW) && phase_over(tick_cnt_reg, low_reg);
  wire high_over = (state_reg == CPO_ST_HIGH) && phase_over(tick_cnt_reg, high_reg);
  // last pulse of a finite run: always for single, at the count for n pulses
  wire last_pulse = (mode_sel == CPO_MODE_SINGLE) ||
                    ((mode_sel == CPO_MODE_NPULSE) &&
                     phase_over(pulse_cnt_reg, pulses_reg));

  // state: start always reenters the low phase, even mid-run
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= CPO_ST_IDLE;
    end else if (start_pulse) begin
      state_reg <= CPO_ST_LOW;
    end else if (tick) begin
      unique case (state_reg)
        CPO_ST_LOW: begin
          if (low_over) begin
            state_reg <= CPO_ST_HIGH;
          end
        end
        CPO_ST_HIGH: begin
          if (high_over) begin
            // modes 2 and 3 never reach the last pulse: endless train
            state_reg <= last_pulse ? CPO_ST_DONE : CPO_ST_LOW;
          end
        end
        CPO_ST_IDLE, CPO_ST_DONE: ; // wait for start
      endcase
    end
  end

  // tick counter: restarts at each phase boundary, still when idle or done
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (start_pulse) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      if (low_over || high_over) begin
        tick_cnt_reg <= 32'h0000_0000;
      end else if (state_reg == CPO_ST_LOW || state_reg == CPO_ST_HIGH) begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // pulse counter: one step at the end of every high phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_cnt_reg <= 32'h0000_0000;
    end else if (start_pulse) begin
      pulse_cnt_reg <= 32'h0000_0000;
    end else if (tick && high_over) begin
      pulse_cnt_reg <= pulse_cnt_reg + 32'h0000_0001;
    end
  end

  // output register: high only in the high phase, low when idle or done
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (state_reg == CPO_ST_HIGH);
    end
  end
endmodule // cpo_counter_output

// ---- tb/cpo_pulse_rx.sv ----
`timescale 1ns/1ps
module cpo_pulse_rx (
  // clock and observed pin
  input wire logic mclk,
  input wire logic pulse_out,
  // measurements in mclk cycles
  output int n_rise,
  output int high_len,
  output int low_len
);
  int run = 0;
  int rises = 0;
  logic prev = 1'b0;
  assign n_rise = rises;
  // equipment only listens: time each level, count rising edges
  always @(posedge mclk) begin
    if (pulse_out !== prev) begin
      if (prev === 1'b1) high_len <= run;
      else low_len <= run;
      if (pulse_out === 1'b1) rises <= rises + 1;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prev <= pulse_out;
  end
endmodule // cpo_pulse_rx

// ---- tb/cpo_chk.sv ----
`timescale 1ns/1ps
module cpo_chk (
  // system
  input wire logic mclk,
  input wire logic rst,
  // bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire cpo_pkg::cpo_word_t avs_readdata,
  input wire logic avs_waitrequest,
  // pin
  input wire logic pulse_out
);
  import cpo_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_ack_one_wait: assert property (s_req |=> !avs_waitrequest) else $error("no ack");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  a_idle_no_ack: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("ack without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h1C
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  // read data may only move in the cycle after a read is asserted
  a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved");
  a_low_min: assert property ($fell(pulse_out) |=> !pulse_out) else $error("short low");
  a_high_min: assert property ($rose(pulse_out) |=> pulse_out) else $error("short high");
  a_quiet_reset: assert property ($fell(rst) |-> !pulse_out && avs_waitrequest)
    else $error("not quiet after reset");
endmodule // cpo_chk
bind cpo_counter_output cpo_chk u_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pulse_out(pulse_out));

// ---- tb/counter_pulse_output_bench.sv ----
`timescale 1ns/1ps
module counter_pulse_output_bench;
  import cpo_pkg::*;
  logic mclk, rst, avs_waitrequest, pulse_out;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic gate_in = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] src_in = 4'h0;
  logic [3:0] sc = 4'h0;
  logic [31:0] d;
  cpo_word_t avs_readdata;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_rise, high_len, low_len, r0;
  cpo_counter_output #(.SRC_COUNT(4), .CYC_PER_MS(5)) dut (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_in(src_in), .gate_in(gate_in),
    .pulse_out(pulse_out));
  cpo_pulse_rx rx (.mclk(mclk), .pulse_out(pulse_out), .n_rise(n_rise),
    .high_len(high_len), .low_len(low_len));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // source 0 rises every 8 cycles, source 1 every 16
  always @(posedge mclk) begin
    sc <= sc + 4'h1;
    src_in <= {sc[0], sc[1], sc[3], sc[2]};
  end
  // hang guard, far above the few thousand cycles needed
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // reset, then low 2, high 3, three pulses
  task automatic rst_cfg;
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h3);
    wr(8'h0C, 32'h3);
  endtask
  task automatic run(input logic [31:0] ctrl, input int n);
    r0 = n_rise;
    wr(8'h00, ctrl);
    repeat (n) @(posedge mclk);
  endtask
  task automatic t_regs;
    rd(8'h10);
    chk(d, 32'h1);
    rd(8'h08);
    chk(d, 32'h3);
    rd(8'h40);
    chk(d, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      rst_cfg();
      run(32'h1 | (m << 1), 300);
      if (m < 2) begin
        chk(n_rise - r0, m ? 3 : 1);
        rd(8'h1C);
        chk(d & 32'h7, 32'h2);
      end else begin
        chk(n_rise - r0 > 4, 1);
      end
      chk(high_len, 24);
    end
    chk(low_len, 16);
    $display("test modes done");
  endtask
  task automatic t_div;
    rst_cfg();
    wr(8'h10, 32'h2);
    run(32'h2B, 700);
    chk(n_rise - r0, 3);
    chk(high_len, 96);
    chk(low_len, 64);
    $display("test divider done");
  endtask
  // a 3-cycle gate glitch must not open a 10-cycle filter
  task automatic t_gate;
    rst_cfg();
    wr(8'h18, 32'h2);
    run(32'h43, 200);
    gate_in <= 1'b1;
    repeat (3) @(posedge mclk);
    gate_in <= 1'b0;
    repeat (100) @(posedge mclk);
    chk(n_rise - r0, 0);
    gate_in <= 1'b1;
    repeat (300) @(posedge mclk);
    chk(n_rise - r0, 3);
    // active-low gate: a held high gate stops, a low gate runs
    run(32'hC3, 300);
    chk(n_rise - r0, 0);
    gate_in <= 1'b0;
    repeat (300) @(posedge mclk);
    chk(n_rise - r0, 3);
    $display("test gate done");
  endtask
  task automatic t_filt;
    rst_cfg();
    wr(8'h14, 32'h1);
    run(32'h3, 300);
    chk(n_rise - r0, 0);
    run(32'h0B, 400);
    chk(n_rise - r0, 3);
    $display("test filter done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    rst_cfg();
    t_regs();
    t_modes();
    t_div();
    t_gate();
    t_filt();
    end_of_test();
  end
endmodule // counter_pulse_output_bench
